// ---- rtl/rbwm_top.sv ----
// ROM bank window mapper: bank select register and flash address routing.
// Assumes CPU address and register strobes are synchronous to mclk.
`timescale 1ns/1ps

module rbwm_top #(
  parameter int NUM_BANKS = rbwm_pkg::NUM_BANKS_LARGE // 6 large, 4 small
) (
  input wire logic mclk, // System clock, 100 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic cpu_req, // CPU fetch or data access valid
  input wire logic [15:0] cpu_addr, // CPU fetch or data address
  input wire logic sfr_wr, // Register write strobe
  input wire logic sfr_rd, // Register read strobe
  input wire logic [15:0] sfr_addr, // Register address
  input wire logic [7:0] sfr_wdata, // Register write data
  output logic [7:0] sfr_rdata, // Register read data
  output logic flash_sel, // Flash access valid
  output logic [rbwm_pkg::FLASH_AW-1:0] flash_addr, // Flash byte address
  output logic code_bad // Prohibited bank code held
);
  // All mapper state lives in one record, cleared as a whole by reset
  // Code, read data and flash outputs share one register stage
  typedef struct packed {
    logic [rbwm_pkg::CODE_W-1:0] code;
    logic [7:0] rdata;
    logic [rbwm_pkg::FLASH_AW-1:0] faddr;
    logic fsel;
    logic bad;
  } rbwm_state_type;

  rbwm_state_type st_q;
  rbwm_state_type st_d;
  rbwm_map_if map_if ();
  logic sel_hit_wr;
  logic sel_hit_rd;

  // Decoder sees the live address and current code
  // Decode is purely combinational; its result is registered below
  // so flash outputs follow a request by exactly one cycle
  assign map_if.addr = cpu_addr;
  assign map_if.code = st_q.code;

  rbwm_decode #(
    .NUM_BANKS(NUM_BANKS)
  ) u_decode (
    .m(map_if)
  );

  // Strobes to other addresses belong to other registers and are dropped
  // Register address match
  // register address decode
  assign sel_hit_wr = sfr_wr && (sfr_addr == rbwm_pkg::SEL_ADDR);
  assign sel_hit_rd = sfr_rd && (sfr_addr == rbwm_pkg::SEL_ADDR);

  // Next state
  always_comb begin
    st_d = st_q;
    if (sel_hit_wr) begin
      st_d.code = sfr_wdata[rbwm_pkg::CODE_LSB +: rbwm_pkg::CODE_W];
    end
    // Read data is a one-cycle pulse; a read beside a write sees the old code
    // upper bits read zero
    st_d.rdata = 8'h00;
    if (sel_hit_rd) begin
      st_d.rdata[rbwm_pkg::CODE_LSB +: rbwm_pkg::CODE_W] = st_q.code;
    end
    st_d.fsel = cpu_req && (map_if.in_common || (map_if.in_window && map_if.code_ok));
    // Address holds between requests so the flash side sees no churn
    st_d.faddr = st_q.faddr;
    if (cpu_req) begin
      st_d.faddr = map_if.flash_off;
    end
    // Flag lags the code by one cycle; absent banks never reach flash
    st_d.bad = !map_if.code_ok;
  end

  // State register
  // Reset branch loads constants only
  // reset clears select
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q.code <= rbwm_pkg::SEL_RESET[rbwm_pkg::CODE_W-1:0];
      st_q.rdata <= 8'h00;
      st_q.faddr <= '0;
      st_q.fsel <= 1'b0;
      st_q.bad <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs from flops
  // Every data output comes straight from a flop, no logic after it
  assign sfr_rdata = st_q.rdata;
  assign flash_sel = st_q.fsel;
  assign flash_addr = st_q.faddr;
  assign code_bad = st_q.bad;

  // Checks below are idle while reset is held; expectations use literals
  // Write stores the low three bits
  a_code_write: assert property (@(posedge mclk) disable iff (!nrst)
    sel_hit_wr |=> st_q.code == $past(sfr_wdata[2:0]))
    else $error("bank code not taken from write");

  // Without a write the code holds
  a_code_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !sel_hit_wr |=> $stable(st_q.code))
    else $error("bank code changed without write");

  // Code is zero right after reset
  a_reset_zero: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(nrst) |-> st_q.code == 3'h0)
    else $error("bank code not cleared by reset");

  // Read returns code with zero upper bits
  a_read_value: assert property (@(posedge mclk) disable iff (!nrst)
    sel_hit_rd |=> sfr_rdata == {5'h00, $past(st_q.code)})
    else $error("register read value wrong");

  // Window access lands in the selected bank
  a_window_route: assert property (@(posedge mclk) disable iff (!nrst)
    (cpu_req && cpu_addr >= 16'h8000 && cpu_addr <= 16'hBFFF) |=>
    flash_addr == 17'h08000 + 17'($past(st_q.code)) * 17'h04000 + 17'($past(cpu_addr) - 16'h8000))
    else $error("window address mapped wrongly");

  // Common area ignores the code
  a_common_route: assert property (@(posedge mclk) disable iff (!nrst)
    (cpu_req && cpu_addr < 16'h8000) |=> flash_sel && flash_addr == 17'($past(cpu_addr)))
    else $error("common address mapped wrongly");

  // No flash access above the window
  a_outside_idle: assert property (@(posedge mclk) disable iff (!nrst)
    (cpu_req && cpu_addr > 16'hBFFF) |=> !flash_sel)
    else $error("flash selected above window");

  // Only present banks are reached
  a_bank_present: assert property (@(posedge mclk) disable iff (!nrst)
    (cpu_req && cpu_addr >= 16'h8000 && cpu_addr <= 16'hBFFF) |=>
    flash_sel == (32'($past(st_q.code)) < NUM_BANKS))
    else $error("absent bank reached");

  // Flag follows code legality
  a_bad_flag: assert property (@(posedge mclk) disable iff (!nrst)
    sel_hit_wr |=> ##1 code_bad == (32'($past(st_q.code)) >= NUM_BANKS))
    else $error("prohibited code flag wrong");

  // No read strobe gives zero on the read bus
  a_read_idle: assert property (@(posedge mclk) disable iff (!nrst)
    !sel_hit_rd |=> sfr_rdata == 8'h00)
    else $error("read data not zero when idle");

  // Upper register bits never read as one
  a_upper_zero: assert property (@(posedge mclk) disable iff (!nrst)
    sfr_rdata[7:3] == 5'h00)
    else $error("upper select bits read as one");

  // Writes to other addresses leave the code alone
  a_other_addr: assert property (@(posedge mclk) disable iff (!nrst)
    (sfr_wr && sfr_addr != 16'hFFF3) |=> $stable(st_q.code))
    else $error("foreign write changed bank code");

  // Flash address holds between requests
  a_addr_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !cpu_req |=> $stable(flash_addr))
    else $error("flash address moved without request");

  // No request, no flash access
  a_idle_nosel: assert property (@(posedge mclk) disable iff (!nrst)
    !cpu_req |=> !flash_sel)
    else $error("flash selected without request");

  // Flash access only follows a request
  a_sel_needs_req: assert property (@(posedge mclk) disable iff (!nrst)
    flash_sel |-> $past(cpu_req))
    else $error("flash select without prior request");

  // Window access to a present bank reaches flash
  a_window_fsel: assert property (@(posedge mclk) disable iff (!nrst)
    (cpu_req && cpu_addr >= 16'h8000 && cpu_addr <= 16'hBFFF && 32'(st_q.code) < NUM_BANKS) |=>
    flash_sel)
    else $error("present bank not selected");

  // Offset within the window passes straight through
  a_window_offset: assert property (@(posedge mclk) disable iff (!nrst)
    (cpu_req && cpu_addr >= 16'h8000 && cpu_addr <= 16'hBFFF) |=>
    flash_addr[13:0] == $past(cpu_addr[13:0]))
    else $error("window offset bits altered");

  // Outputs idle on the first edge after reset
  a_reset_outputs: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(nrst) |-> !flash_sel && !code_bad && sfr_rdata == 8'h00)
    else $error("outputs not idle after reset");

  // Bank number plus two appears in binary above the offset
  a_code_binary: assert property (@(posedge mclk) disable iff (!nrst)
    (cpu_req && cpu_addr >= 16'h8000 && cpu_addr <= 16'hBFFF && 32'(st_q.code) < NUM_BANKS) |=>
    flash_addr[16:14] == 3'($past(st_q.code) + 3'h2))
    else $error("bank number bits wrong");

  // Flag changes only two edges after a register write
  a_bad_cause: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(code_bad) |-> $past(sel_hit_wr, 2))
    else $error("prohibited code flag moved without write");

  // Addresses above the window still update the flash address
  a_above_addr: assert property (@(posedge mclk) disable iff (!nrst)
    (cpu_req && cpu_addr > 16'hBFFF) |=> flash_addr == 17'($past(cpu_addr)))
    else $error("address above window not passed");

  // Common area always reaches flash
  a_common_sel: assert property (@(posedge mclk) disable iff (!nrst)
    (cpu_req && cpu_addr <= 16'h7FFF) |=> flash_sel)
    else $error("common area not selected");
endmodule // rbwm_top

// ---- inc/rbwm_pkg.sv ----
// Constants for the ROM bank window mapper.
// Assumes a 16-bit CPU address space and a flash array addressed by byte.
package rbwm_pkg;
  localparam logic [15:0] SEL_ADDR = 16'hFFF3; // Bank select register address
  localparam logic [7:0] SEL_RESET = 8'h00; // Select value after reset
  localparam int CODE_W = 3; // Width of the bank code field
  localparam int CODE_LSB = 0; // Position of the bank code field
  localparam logic [15:0] WIN_LO = 16'h8000; // First window address
  localparam logic [15:0] WIN_HI = 16'hBFFF; // Last window address
  localparam logic [15:0] COMMON_HI = 16'h7FFF; // Last common area address
  localparam int FLASH_AW = 17; // Flash byte address width
  localparam logic [16:0] COMMON_SIZE = 17'h08000; // 32 K common area
  localparam logic [16:0] BANK_SIZE = 17'h04000; // 16 K per bank
  localparam int NUM_BANKS_LARGE = 6; // Banks on the larger variant
  localparam int NUM_BANKS_SMALL = 4; // Banks on the smaller variant
endpackage

// ---- inc/rbwm_map_if.sv ----
// Carrier between the mapper top and its address decoder.
// Assumes both ends sit in the mclk domain.
`timescale 1ns/1ps
interface rbwm_map_if;
  logic [15:0] addr; // CPU address to decode
  logic [rbwm_pkg::CODE_W-1:0] code; // Current bank code
  logic [rbwm_pkg::FLASH_AW-1:0] flash_off; // Resulting flash offset
  logic in_common; // Address in common area
  logic in_window; // Address in bank window
  logic code_ok; // Code names an existing bank
  modport top (output addr, output code, input flash_off, input in_common, input in_window, input code_ok);
  modport dec (input addr, input code, output flash_off, output in_common, output in_window, output code_ok);
endinterface

// ---- rtl/rbwm_decode.sv ----
// Combinational address decoder for the bank window.
// Assumes the bank code is held stable by the caller.
`timescale 1ns/1ps
module rbwm_decode #(
  parameter int NUM_BANKS = rbwm_pkg::NUM_BANKS_LARGE // Banks present
) (
  rbwm_map_if.dec m // Decode request and result
);
  logic [rbwm_pkg::FLASH_AW-1:0] bank_base;
  logic [rbwm_pkg::FLASH_AW-1:0] win_off;

  // Window base is 32 K plus bank times 16 K
  // window offset math
  always_comb begin
    bank_base = rbwm_pkg::COMMON_SIZE + rbwm_pkg::FLASH_AW'(m.code) * rbwm_pkg::BANK_SIZE;
    win_off = rbwm_pkg::FLASH_AW'(m.addr - rbwm_pkg::WIN_LO);
  end

  // Region and code legality
  // binary code decode
  assign m.in_common = (m.addr <= rbwm_pkg::COMMON_HI);
  assign m.in_window = (m.addr >= rbwm_pkg::WIN_LO) && (m.addr <= rbwm_pkg::WIN_HI);
  assign m.code_ok = (32'(m.code) < NUM_BANKS);
  assign m.flash_off = m.in_window ? (bank_base + win_off) : rbwm_pkg::FLASH_AW'(m.addr);
endmodule // rbwm_decode

// ---- verif/rbwm_cpu_model.sv ----
// CPU side model: issues one fetch or data address per call.
// Assumes the mapper samples its inputs on rising mclk.
`timescale 1ns/1ps
module rbwm_cpu_model (
  input wire logic mclk, // System clock
  output logic cpu_req, // Access valid
  output logic [15:0] cpu_addr // Access address
);
  initial begin
    cpu_req = 1'b0;
    cpu_addr = 16'h0000;
  end
  // One access cycle, then the bus is released with a changed address
  task automatic access(input logic [15:0] a);
    @(negedge mclk);
    cpu_req = 1'b1;
    cpu_addr = a;
    @(negedge mclk);
    cpu_req = 1'b0;
    cpu_addr = ~a;
  endtask
endmodule // rbwm_cpu_model

// ---- verif/tb_top.sv ----
// Testbench for the bank window mapper: select register and flash routing.
// Assumes a 100 MHz mclk and inputs driven at the falling edge.
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [15:0] sfr_addr = 16'h0000;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic cpu_req;
  logic [15:0] cpu_addr;
  logic flash_sel;
  logic [16:0] flash_addr;
  logic code_bad;
  logic bad_small;
  logic [7:0] sfr_rdata_s;
  logic flash_sel_s;
  logic [16:0] flash_addr_s;
  logic [16:0] exp_a;
  int error_cnt = 0;
  int n_compared = 0;
  // Clock, 10 ns period
  always #5 mclk = ~mclk;
  rbwm_cpu_model cpu (.mclk(mclk), .cpu_req(cpu_req), .cpu_addr(cpu_addr));
  rbwm_top #(.NUM_BANKS(6)) DUT (.mclk(mclk), .nrst(nrst), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .flash_sel(flash_sel), .flash_addr(flash_addr), .code_bad(code_bad));
  rbwm_top #(.NUM_BANKS(4)) DUT_small (.mclk(mclk), .nrst(nrst), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata_s),
    .flash_sel(flash_sel_s), .flash_addr(flash_addr_s), .code_bad(bad_small));
  // Compare and count
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask
  // Read strobe; data is looked at on the falling edge that ends it
  task automatic rd();
    @(negedge mclk);
    sfr_rd = 1'b1;
    sfr_addr = rbwm_pkg::SEL_ADDR;
    @(negedge mclk);
    sfr_rd = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    rd();
    chk(sfr_rdata, 18'h00000);
    for (int k = 0; k < 6; k++) begin
      wr(rbwm_pkg::SEL_ADDR, 8'hF8 | k[7:0]);
      rd();
      chk(sfr_rdata, 18'(k));
      chk(sfr_rdata_s, 18'(k));
      chk({code_bad, bad_small}, {16'h0000, 2'(k >= 4)});
      exp_a = 17'(32'h8000 + k * 32'h4000 + 32'h3FFF - k);
      cpu.access(16'hBFFF - k[15:0]);
      chk({flash_sel, flash_addr}, {1'b1, exp_a});
      chk({flash_sel_s, flash_addr_s}, {1'(k < 4), exp_a});
      cpu.access(16'h7FFF);
      chk({flash_sel, flash_addr}, {1'b1, 17'h07FFF});
      chk({flash_sel_s, flash_addr_s}, {1'b1, 17'h07FFF});
    end
    $display("test bank routing done");
    for (int c = 6; c < 8; c++) begin
      wr(rbwm_pkg::SEL_ADDR, c[7:0]);
      rd();
      chk({code_bad, sfr_rdata}, {9'h001, c[7:0]});
      cpu.access(16'h8000);
      chk(flash_sel, 18'h00000);
      chk(flash_sel_s, 18'h00000);
    end
    cpu.access(16'hC000);
    chk(flash_sel, 18'h00000);
    chk(flash_sel_s, 18'h00000);
    wr(16'hFFF2, 8'h01);
    rd();
    chk(sfr_rdata, 18'h00007);
    $display("test prohibited codes done");
    @(negedge mclk);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    rd();
    chk(sfr_rdata, 18'h00000);
    cpu.access(16'h8123);
    chk({flash_sel, flash_addr}, {1'b1, 17'h08123});
    cpu.access(16'h7FFF);
    chk({flash_sel, flash_addr}, {1'b1, 17'h07FFF});
    cpu.access(16'h8000);
    chk({flash_sel, flash_addr}, {1'b1, 17'h08000});
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule // tb_top
